// ==== hw/acs_pkg.sv ====
// package: constants and types for the adc autoscan sequencer
`default_nettype none
package acs_pkg;
  localparam int CONV_CYCLES = 138;
  localparam int SAMPLE_CYCLES = 84;
  localparam int DATA_W = 8;
  localparam int CHAN_W = 3;
  localparam logic [2:0] LAST_CHAN = 3'h7;
  localparam logic [2:0] WD_CHAN_A = 3'h6;
  localparam logic [2:0] WD_CHAN_B = 3'h7;
  // threshold_flags field positions
  localparam int FLAG_HI_B = 7;
  localparam int FLAG_HI_A = 6;
  localparam int FLAG_LO_B = 5;
  localparam int FLAG_LO_A = 4;
  localparam logic [3:0] FLAG_LOW_ONES = 4'hF;
  localparam logic [3:0] FLAGS_RESET = 4'h0;
  localparam logic [7:0] DATA_RESET = 8'h00;
  // bias settle time before first start, kept by software
  localparam int BIAS_SETTLE_US = 60;
  localparam int CLOCK_MHZ = 100;
  localparam int BIAS_SETTLE_CYCLES = BIAS_SETTLE_US * CLOCK_MHZ;
  // irq_vector_reg source codes
  localparam logic [1:0] VEC_NONE = 2'h0;
  localparam logic [1:0] VEC_WINDOW = 2'h1;
  localparam logic [1:0] VEC_DONE = 2'h2;
  typedef enum logic [2:0] {
    ACS_IDLE = 3'b001,
    ACS_SAMPLE = 3'b010,
    ACS_CONVERT = 3'b100
  } acs_state_t;
endpackage
`default_nettype wire

// ==== hw/acs_sequencer.sv ====
// adc autoscan sequencer: scan control, triggers, window watchdogs, irq sources
`default_nettype none
// Overview of operation
// - 138 cycles per channel, first 84 sampling
// - results are eight bits wide
// - repeat_select one continuous, zero single
// - scan from start_channel upward to channel 7
// - conversion_run starts scan, results stored
// - single mode clears run, raises done
// - continuous mode restarts at start channel
// - done request each time channel 7 ends
// - new result overwrites channel data register
// - gated pin and timer triggers ORed
// - triggers ignored while conversion_run set
// - channels 6,7 window violation sets flags
// - upper four flag bits, lower read one
// - flags cleared at reset and alarm clear
// - bias off at reset and in halt
// - vector register flags the interrupt source
// - window alarm pending set on violation
// - window request served before done request
// - software pending write raises request
// - control write aborts and reinitialises scan
module acs_sequencer
  import acs_pkg::*;
#(
  parameter int CONV_LEN = CONV_CYCLES,
  parameter int SAMPLE_LEN = SAMPLE_CYCLES
) (
  // clock and reset
  input wire logic clock,
  input wire logic reset_n,
  // sequencer_control write port
  input wire logic ctrl_write,
  input wire logic [2:0] start_channel_in,
  input wire logic pin_trigger_enable_in,
  input wire logic timer_trigger_enable_in,
  input wire logic analog_bias_on_in,
  input wire logic repeat_select_in,
  input wire logic conversion_run_in,
  // irq_control_reg pending bit writes
  input wire logic pending_write,
  input wire logic sequence_done_pending_in,
  input wire logic window_alarm_pending_in,
  // threshold registers
  input wire logic [7:0] lower_thresh_6,
  input wire logic [7:0] lower_thresh_7,
  input wire logic [7:0] upper_thresh_6,
  input wire logic [7:0] upper_thresh_7,
  // processor halt and trigger sources
  input wire logic halt_mode,
  input wire logic trigger_pin,
  input wire logic timer_trigger,
  // converter core
  input wire logic [7:0] core_result,
  output logic [2:0] mux_channel,
  output logic sample_phase,
  output logic conversion_active,
  output logic analog_bias_on,
  // status
  output logic conversion_run,
  output logic [2:0] start_channel,
  output logic repeat_select,
  output logic pin_trigger_enable,
  output logic timer_trigger_enable,
  output logic [63:0] channel_data,
  output logic [7:0] threshold_flags,
  output logic sequence_done_pending,
  output logic window_alarm_pending,
  output logic [1:0] irq_vector_reg,
  output logic irq_request
);

  acs_state_t state;
  logic [7:0] cycle_cnt;
  logic pin_s1, pin_s2, pin_s3, pin_level;
  logic timer_q;
  logic [3:0] flags;
  logic [7:0] data_mem [8];
  logic conv_end, last_end, trig_event, pin_fall, timer_fall;
  logic hit_hi_a, hit_hi_b, hit_lo_a, hit_lo_b, any_hit;

  function automatic logic [8:0] window_hit(input logic [7:0] v, input logic [7:0] lo,
                                            input logic [7:0] hi);
    window_hit = {1'b0, 6'h00, (v >= hi), (v < lo)};
  endfunction

  // pin trigger: three-stage synchroniser, a level counts once stages two and three agree
  always_ff @(posedge clock or negedge reset_n) begin
    if (!reset_n) begin
      pin_s1 <= 1'b1;
      pin_s2 <= 1'b1;
      pin_s3 <= 1'b1;
      pin_level <= 1'b1;
    end else begin
      pin_s1 <= trigger_pin;
      pin_s2 <= pin_s1;
      pin_s3 <= pin_s2;
      if (pin_s2 == pin_s3) begin
        pin_level <= pin_s3;
      end
    end
  end

  // timer trigger comes from on-chip logic, no synchroniser
  always_ff @(posedge clock or negedge reset_n) begin
    if (!reset_n) begin
      timer_q <= 1'b1;
    end else begin
      timer_q <= timer_trigger;
    end
  end

  // triggers are active-low pulses; the falling edge starts a scan
  assign pin_fall = (pin_s2 == pin_s3) && pin_level && !pin_s3;
  assign timer_fall = timer_q && !timer_trigger;
  assign trig_event = (pin_fall && pin_trigger_enable) ||
                      (timer_fall && timer_trigger_enable);

  assign conv_end = (state == ACS_CONVERT) && (cycle_cnt == 8'(CONV_LEN - 1));
  assign last_end = conv_end && (mux_channel == LAST_CHAN);

  // control fields
  always_ff @(posedge clock or negedge reset_n) begin
    if (!reset_n) begin
      start_channel <= 3'h0;
      pin_trigger_enable <= 1'b0;
      timer_trigger_enable <= 1'b0;
      repeat_select <= 1'b0;
    end else if (ctrl_write) begin
      start_channel <= start_channel_in;
      pin_trigger_enable <= pin_trigger_enable_in;
      timer_trigger_enable <= timer_trigger_enable_in;
      repeat_select <= repeat_select_in;
    end
  end

  // bias bit: halt forces power down, which beats a same-cycle write
  always_ff @(posedge clock or negedge reset_n) begin
    if (!reset_n) begin
      analog_bias_on <= 1'b0;
    end else if (halt_mode) begin
      analog_bias_on <= 1'b0;
    end else if (ctrl_write) begin
      analog_bias_on <= analog_bias_on_in;
    end
  end

  // run bit: a trigger while running is dropped, so a continuous scan sees only the first
  always_ff @(posedge clock or negedge reset_n) begin
    if (!reset_n) begin
      conversion_run <= 1'b0;
    end else if (ctrl_write) begin
      conversion_run <= conversion_run_in;
    end else if (trig_event && !conversion_run) begin
      conversion_run <= 1'b1;
    end else if (last_end && !repeat_select) begin
      conversion_run <= 1'b0;
    end
  end

  // scan state machine; a control write drops any conversion in flight
  always_ff @(posedge clock or negedge reset_n) begin
    if (!reset_n) begin
      state <= ACS_IDLE;
      cycle_cnt <= 8'h00;
      mux_channel <= 3'h0;
    end else if (ctrl_write) begin
      state <= ACS_IDLE;
      cycle_cnt <= 8'h00;
      mux_channel <= start_channel_in;
    end else begin
      case (state)
        ACS_IDLE: begin
          cycle_cnt <= 8'h00;
          mux_channel <= start_channel;
          if (conversion_run) begin
            state <= ACS_SAMPLE;
          end
        end
        ACS_SAMPLE: begin
          cycle_cnt <= cycle_cnt + 8'h01;
          if (cycle_cnt == 8'(SAMPLE_LEN - 1)) begin
            state <= ACS_CONVERT;
          end
        end
        ACS_CONVERT: begin
          cycle_cnt <= cycle_cnt + 8'h01;
          if (conv_end) begin
            cycle_cnt <= 8'h00;
            if (mux_channel != LAST_CHAN) begin
              mux_channel <= mux_channel + 3'h1;
              state <= ACS_SAMPLE;
            end else if (repeat_select && conversion_run) begin
              mux_channel <= start_channel;
              state <= ACS_SAMPLE;
            end else begin
              state <= ACS_IDLE;
            end
          end else if (!conversion_run) begin
            state <= ACS_IDLE;
          end
        end
        default: state <= ACS_IDLE;
      endcase
    end
  end

  always_ff @(posedge clock or negedge reset_n) begin
    if (!reset_n) begin
      sample_phase <= 1'b0;
      conversion_active <= 1'b0;
    end else begin
      sample_phase <= (state == ACS_SAMPLE);
      conversion_active <= (state != ACS_IDLE);
    end
  end

  // result storage: the full word is replaced, the old value is lost
  always_ff @(posedge clock or negedge reset_n) begin
    if (!reset_n) begin
      for (int i = 0; i < 8; i++) begin
        data_mem[i] <= DATA_RESET;
      end
    end else if (conv_end) begin
      data_mem[mux_channel] <= core_result;
    end
  end

  always_ff @(posedge clock or negedge reset_n) begin
    if (!reset_n) begin
      channel_data <= 64'h0;
    end else begin
      for (int i = 0; i < 8; i++) begin
        channel_data[i*DATA_W +: DATA_W] <= data_mem[i];
      end
    end
  end

  // window compare on channels 6 and 7
  logic [8:0] win_a, win_b;
  assign win_a = window_hit(core_result, lower_thresh_6, upper_thresh_6);
  assign win_b = window_hit(core_result, lower_thresh_7, upper_thresh_7);
  assign hit_hi_a = conv_end && (mux_channel == WD_CHAN_A) && win_a[1];
  assign hit_lo_a = conv_end && (mux_channel == WD_CHAN_A) && win_a[0];
  assign hit_hi_b = conv_end && (mux_channel == WD_CHAN_B) && win_b[1];
  assign hit_lo_b = conv_end && (mux_channel == WD_CHAN_B) && win_b[0];
  assign any_hit = hit_hi_a || hit_lo_a || hit_hi_b || hit_lo_b;

  // flags: a new hit wins over the clear that comes with the alarm clear
  always_ff @(posedge clock or negedge reset_n) begin
    if (!reset_n) begin
      flags <= FLAGS_RESET;
    end else begin
      if (pending_write && !window_alarm_pending_in) begin
        flags <= {hit_hi_b, hit_hi_a, hit_lo_b, hit_lo_a};
      end else begin
        flags <= flags | {hit_hi_b, hit_hi_a, hit_lo_b, hit_lo_a};
      end
    end
  end

  always_ff @(posedge clock or negedge reset_n) begin
    if (!reset_n) begin
      threshold_flags <= {FLAGS_RESET, FLAG_LOW_ONES};
    end else begin
      threshold_flags <= {flags, FLAG_LOW_ONES};
    end
  end

  // pending bits: hardware set wins over software clear; software set raises a request
  always_ff @(posedge clock or negedge reset_n) begin
    if (!reset_n) begin
      window_alarm_pending <= 1'b0;
      sequence_done_pending <= 1'b0;
    end else begin
      if (any_hit) begin
        window_alarm_pending <= 1'b1;
      end else if (pending_write) begin
        window_alarm_pending <= window_alarm_pending_in;
      end
      if (last_end) begin
        sequence_done_pending <= 1'b1;
      end else if (pending_write) begin
        sequence_done_pending <= sequence_done_pending_in;
      end
    end
  end

  // fixed priority: window alarm first, done held pending behind it
  always_ff @(posedge clock or negedge reset_n) begin
    if (!reset_n) begin
      irq_vector_reg <= VEC_NONE;
      irq_request <= 1'b0;
    end else begin
      irq_request <= window_alarm_pending || sequence_done_pending;
      if (window_alarm_pending) begin
        irq_vector_reg <= VEC_WINDOW;
      end else if (sequence_done_pending) begin
        irq_vector_reg <= VEC_DONE;
      end else begin
        irq_vector_reg <= VEC_NONE;
      end
    end
  end

endmodule // acs_sequencer
`default_nettype wire

// ==== verif/acs_monitor.sv ====
// checker: port assertions for the adc autoscan sequencer
`default_nettype none
module acs_monitor
  import acs_pkg::*;
#(
  parameter int CONV_LEN = CONV_CYCLES,
  parameter int SAMPLE_LEN = SAMPLE_CYCLES
) (
  // clock, reset and inputs
  input wire logic clock,
  input wire logic reset_n,
  input wire logic ctrl_write,
  input wire logic conversion_run_in,
  input wire logic [2:0] start_channel_in,
  input wire logic pending_write,
  input wire logic window_alarm_pending_in,
  input wire logic halt_mode,
  // outputs
  input wire logic sample_phase,
  input wire logic conversion_active,
  input wire logic analog_bias_on,
  input wire logic conversion_run,
  input wire logic [2:0] start_channel,
  input wire logic repeat_select,
  input wire logic [63:0] channel_data,
  input wire logic [7:0] threshold_flags,
  input wire logic sequence_done_pending,
  input wire logic window_alarm_pending,
  input wire logic [1:0] irq_vector_reg,
  input wire logic irq_request
);
  default clocking cb @(posedge clock);
  endclocking
  default disable iff (!reset_n);
  // counts restart on each sample start, so an abort never leaves a stale count
  int scnt;
  int acnt;
  logic sp_q;
  always_ff @(posedge clock or negedge reset_n) begin
    if (!reset_n) begin
      scnt <= 0;
      acnt <= 0;
      sp_q <= 1'b0;
    end else begin
      scnt <= sample_phase ? scnt + 1 : 0;
      acnt <= (sample_phase && !sp_q) ? 1 : acnt + 1;
      sp_q <= sample_phase;
    end
  end
  chk_sample_len: assert property (
    $fell(sample_phase) && conversion_active |-> scnt == SAMPLE_LEN)
    else $error("sample phase length wrong");
  chk_store_time: assert property (
    channel_data != $past(channel_data) |-> acnt == CONV_LEN)
    else $error("result stored at wrong time");
  chk_run_done: assert property (
    $fell(conversion_run) && !$past(ctrl_write) && !repeat_select |-> sequence_done_pending)
    else $error("run cleared without done request");
  chk_flags_low: assert property (
    threshold_flags[3:0] == FLAG_LOW_ONES)
    else $error("flag low nibble not ones");
  chk_bias_halt: assert property (
    $past(halt_mode) |-> !analog_bias_on)
    else $error("bias on during halt");
  chk_irq_level: assert property (
    irq_request == ($past(sequence_done_pending) || $past(window_alarm_pending)))
    else $error("irq request mismatch");
  chk_vec_prio: assert property (
    irq_vector_reg == ($past(window_alarm_pending) ? VEC_WINDOW :
      $past(sequence_done_pending) ? VEC_DONE : VEC_NONE))
    else $error("vector source mismatch");
  chk_ctrl_abort: assert property (
    ctrl_write |=> (conversion_run == $past(conversion_run_in) &&
      start_channel == $past(start_channel_in)) ##1 !conversion_active)
    else $error("control write did not reinitialise");
  // threshold_flags lags the internal flags by one register stage
  chk_flag_clear: assert property (
    pending_write && !window_alarm_pending_in |-> ##2
      (threshold_flags[7:4] == FLAGS_RESET || window_alarm_pending))
    else $error("flags not cleared with alarm");
  cover property ($fell(conversion_run));
  cover property (window_alarm_pending && sequence_done_pending);
  cover property (ctrl_write && conversion_active);
endmodule // acs_monitor
bind acs_sequencer acs_monitor #(.CONV_LEN(CONV_LEN), .SAMPLE_LEN(SAMPLE_LEN)) mon_u (.*);
`default_nettype wire

// ==== verif/acs_core_model.sv ====
// partner model: converter core giving a channel-dependent result
`default_nettype none
module acs_core_model (
  // from the sequencer
  input wire logic clock,
  input wire logic [2:0] mux_channel,
  input wire logic conversion_active,
  // result level chosen by the bench
  input wire logic [7:0] level,
  output logic [7:0] core_result
);
  timeunit 1ns;
  timeprecision 1ps;
  logic [7:0] junk = 8'h5A;
  // outside a conversion the output toggles, so a misplaced sample never matches
  always_ff @(posedge clock) begin
    junk <= ~junk;
  end
  assign core_result = conversion_active ? level + {5'h0, mux_channel} : junk;
endmodule // acs_core_model
`default_nettype wire

// ==== verif/tb_adc_autoscan_sequencer.sv ====
// testbench: scans, triggers, window watchdogs and irq sources
`default_nettype none
module tb_adc_autoscan_sequencer import acs_pkg::*;;
  timeunit 1ns;
  timeprecision 1ps;
  logic clock = 1'b0, reset_n = 1'b0, ctrl_write = 1'b0, pending_write = 1'b0;
  logic pin_trigger_enable_in = 1'b0, timer_trigger_enable_in = 1'b0, halt_mode = 1'b0;
  logic analog_bias_on_in = 1'b1, repeat_select_in = 1'b0, conversion_run_in = 1'b0;
  logic sequence_done_pending_in = 1'b0, window_alarm_pending_in = 1'b0;
  logic trigger_pin = 1'b1, timer_trigger = 1'b1;
  logic [2:0] start_channel_in = 3'h0, mux_channel, start_channel;
  logic [7:0] lower_thresh_6 = 8'h00, lower_thresh_7 = 8'h00, level = 8'h00;
  logic [7:0] upper_thresh_6 = 8'hFF, upper_thresh_7 = 8'hFF, core_result, threshold_flags;
  logic sample_phase, conversion_active, analog_bias_on, conversion_run, repeat_select;
  logic pin_trigger_enable, timer_trigger_enable, sequence_done_pending;
  logic window_alarm_pending, irq_request;
  logic [1:0] irq_vector_reg;
  logic [63:0] channel_data, exp_data = 64'h0;
  int err_count = 0, n_checks = 0;
  always #5 clock = ~clock;
  acs_sequencer #(.CONV_LEN(10), .SAMPLE_LEN(4)) dut_u (.*);
  acs_core_model model_u (.clock, .mux_channel, .conversion_active, .level, .core_result);
  task automatic chk(input string what, input logic [63:0] got, input logic [63:0] exp);
    n_checks++;
    if (got !== exp) begin
      err_count++;
      $display("[ERR] %s expected %h seen %h", what, exp, got);
    end
  endtask
  task automatic cyc(input int n);
    repeat (n) @(posedge clock);
    #1;
  endtask
  task automatic wr(input logic run, input logic [2:0] s, input logic rep, input logic pin,
      input logic tim);
    {conversion_run_in, start_channel_in, repeat_select_in} = {run, s, rep};
    {pin_trigger_enable_in, timer_trigger_enable_in} = {pin, tim};
    ctrl_write = 1'b1;
    cyc(1);
    ctrl_write = 1'b0;
  endtask
  task automatic pend(input logic done, input logic win);
    {sequence_done_pending_in, window_alarm_pending_in} = {done, win};
    pending_write = 1'b1;
    cyc(1);
    pending_write = 1'b0;
    cyc(1);
  endtask
  task automatic wait_done();
    int k = 0;
    while (sequence_done_pending !== 1'b1 && k < 200) begin
      cyc(1);
      k++;
    end
    chk("done", sequence_done_pending, 1'b1);
    cyc(2);
  endtask
  function automatic logic [63:0] scan(input logic [2:0] s, input logic [7:0] b);
    scan = exp_data;
    for (int c = s; c < 8; c++) scan[8*c +: 8] = b + 8'(c);
  endfunction
  task automatic single(input logic [2:0] s);
    level = 8'($urandom) & 8'h7F;
    exp_data = scan(s, level);
    wr(1'b1, s, 1'b0, 1'b0, 1'b0);
    chk("run", conversion_run, 1'b1);
    wait_done();
    chk("data", channel_data, exp_data);
    chk("run off", conversion_run, 1'b0);
    chk("vector", irq_vector_reg, VEC_DONE);
    chk("flags", threshold_flags, 8'h0F);
    pend(1'b0, 1'b0);
    chk("irq", irq_request, 1'b0);
    $display("single scan from %0d done", s);
  endtask
  task automatic trig(input logic pin);
    if (pin) trigger_pin = 1'b0; // low two cycles
    else timer_trigger = 1'b0;
    cyc(2);
    {trigger_pin, timer_trigger} = 2'b11;
    cyc(5);
  endtask
  task automatic results();
    $display("checks %0d mismatches %0d", n_checks, err_count);
    if (err_count == 0 && n_checks > 0) $display("Simulation passed");
    else $display("Simulation failed");
    $finish;
  endtask
  initial begin
    void'($urandom(81));
    cyc(16);
    reset_n = 1'b1;
    chk("reset", {threshold_flags, analog_bias_on}, {8'h0F, 1'b0});
    chk("reset data", channel_data, 64'h0);
    wr(1'b0, 3'h0, 1'b0, 1'b0, 1'b0);
    cyc(BIAS_SETTLE_CYCLES); // bias settles before any start
    single(3'h7);
    single(3'h0);
    for (int i = 0; i < 5; i++) single(3'($urandom));
    {upper_thresh_7, lower_thresh_6, upper_thresh_6, lower_thresh_7} = 32'h00FF_1617;
    level = 8'h10;
    exp_data = scan(3'h6, level);
    wr(1'b1, 3'h6, 1'b0, 1'b0, 1'b0);
    wait_done();
    chk("hit", {threshold_flags, window_alarm_pending}, 9'h1BF);
    chk("prio", irq_vector_reg, VEC_WINDOW);
    pend(1'b1, 1'b0);
    chk("clear", {threshold_flags, irq_vector_reg}, {8'h0F, VEC_DONE});
    pend(1'b0, 1'b1);
    chk("sw set", {irq_request, irq_vector_reg}, {1'b1, VEC_WINDOW});
    pend(1'b0, 1'b0);
    {upper_thresh_7, lower_thresh_6, upper_thresh_6, lower_thresh_7} = 32'hFF00_FF00;
    $display("window test done");
    wr(1'b0, 3'h5, 1'b1, 1'b0, 1'b1); // one trigger source only
    level = 8'h20;
    exp_data = scan(3'h5, level);
    chk("ctrl", {pin_trigger_enable, timer_trigger_enable, repeat_select, start_channel},
        {1'b0, 1'b1, 1'b1, 3'h5});
    trig(1'b0);
    chk("timer run", conversion_run, 1'b1);
    wait_done();
    pend(1'b0, 1'b0);
    trig(1'b0);
    wait_done();
    chk("cont", {conversion_run, channel_data}, {1'b1, exp_data});
    wr(1'b0, 3'h5, 1'b1, 1'b0, 1'b0);
    cyc(2);
    chk("abort", {conversion_run, conversion_active, mux_channel}, {2'b00, 3'h5});
    pend(1'b0, 1'b0);
    $display("continuous test done");
    wr(1'b0, 3'h7, 1'b0, 1'b1, 1'b0);
    level = 8'h33;
    exp_data = scan(3'h7, level);
    trig(1'b1);
    chk("pin run", conversion_run, 1'b1);
    wait_done();
    chk("pin data", channel_data, exp_data);
    pend(1'b0, 1'b0);
    wr(1'b0, 3'h7, 1'b0, 1'b0, 1'b0);
    trig(1'b0);
    chk("gated", conversion_run, 1'b0);
    halt_mode = 1'b1;
    cyc(2);
    chk("halt", analog_bias_on, 1'b0);
    halt_mode = 1'b0;
    $display("trigger and halt test done");
    results();
  end
  // all tests need well under 20000 cycles, bias wait included
  initial begin
    repeat (30000) @(posedge clock);
    err_count++;
    results();
  end
endmodule // tb_adc_autoscan_sequencer
`default_nettype wire
